// >>> inc/dps_params.svh
/*
 * Constants for the switching and compensation block: timing counts,
 * interleave encoding, field widths and reset values.
 * Assumes it is included by its bare name from the package and the design.
 */
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// Core clock rate in kHz (40 ns period)
`define DPS_CLK_KHZ 25000
// Sync line rate in kHz
`define DPS_SYNC_KHZ 500
// Switching rates in kHz
`define DPS_FSW_LO_KHZ 500
`define DPS_FSW_HI_KHZ 1000
// Cycles of clk per switching period
`define DPS_PER_LO (`DPS_CLK_KHZ / `DPS_FSW_LO_KHZ)
`define DPS_PER_HI (`DPS_CLK_KHZ / `DPS_FSW_HI_KHZ)
// Interleave phase steps per period (22.5 degrees each)
`define DPS_PHASE_STEPS 16
// Widths
`define DPS_CNT_W 8
`define DPS_COEF_W 16
`define DPS_ERR_W 12
`define DPS_ACC_W 32
// PRBS seed and duty limit reset (full scale)
`define DPS_PRBS_SEED 15'h7fff
`define DPS_DUTY_LIM_RST 8'hff
// Fraction bits of the loop arithmetic
`define DPS_FRAC 8
// Sync loss limit: cycles without a sync edge before unlocked
`define DPS_LOCK_TMO 8'h64

`endif

// >>> inc/dps_pkg.sv
/*
 * Types for the switching and compensation block.
 * Assumes dps_params.svh is on the include path.
 */
`include "dps_params.svh"

package dps_pkg;
    // Switching rate selection
    typedef enum logic {
        DPS_FSW_500K = 1'b0,
        DPS_FSW_1M = 1'b1
    } dps_fsw_e;

    // Interleave configuration as applied
    typedef struct packed {
        dps_fsw_e fsw;
        logic [3:0] phase;
    } dps_ilv_s;

    // Compensation coefficients
    typedef struct packed {
        logic signed [`DPS_COEF_W-1:0] prop;
        logic signed [`DPS_COEF_W-1:0] integ;
        logic signed [`DPS_COEF_W-1:0] deriv;
        logic signed [`DPS_COEF_W-1:0] rolloff;
    } dps_coef_s;

    // Period phase
    typedef enum logic [1:0] {
        DPS_ST_IDLE = 2'b00,
        DPS_ST_WAIT = 2'b01,
        DPS_ST_RUN = 2'b10
    } dps_state_e;
endpackage

// >>> rtl/dps_pwm_core.sv
/*
 * Digital PWM with sync-line locking, interleave, duty limit, PID
 * compensation and PRBS plant identification.
 * Assumes: sync_line arrives from the power manager on its own clock
 * (sync_clk samples it); error samples come from an ADC on clk.
 */
// Summary of operation
// - Switching rate selects 500 kHz or 1 MHz.
// - Interleave config applied only while output off.
// - Lock loop tracks the 500 kHz sync line.
// - Switching follows sync line falling edge.
// - Each converter applies its own rate selection.
// - Period start delayed by 22.5 degree phase steps.
// - Writable duty limit register caps duty.
// - Duty trimmed above or below ideal ratio.
// - Feedback is programmable PID with roll-off.
// - Each coefficient held in own register.
// - PRBS injected into PWM, response observable.
`timescale 1ns/1ps
`include "dps_params.svh"

module dps_pwm_core
    import dps_pkg::*;
#(
    parameter int CNT_W = `DPS_CNT_W
) (
    // Clocks, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic sync_clk,
    // Sync line from the power manager
    input wire logic sync_line,
    // Configuration writes (one-cycle strobes with data)
    input wire logic ilv_wr,
    input wire dps_ilv_s ilv_wdata,
    input wire logic duty_wr,
    input wire logic [CNT_W-1:0] duty_wdata,
    input wire logic coef_wr,
    input wire dps_coef_s coef_wdata,
    // Operation
    input wire logic output_on,
    input wire logic plant_identification,
    input wire logic [CNT_W-1:0] ideal_duty,
    input wire logic signed [`DPS_ERR_W-1:0] vout_err,
    // Outputs
    output logic pwm_out,
    output logic locked,
    output logic prbs_bit,
    output dps_ilv_s ilv_reg_q,
    output logic [CNT_W-1:0] duty_limit_reg_q,
    output logic [CNT_W-1:0] duty_cmd,
    output logic signed [`DPS_ERR_W-1:0] vout_resp
);

    // Sync-domain state: sample, falling-edge detect, event toggle
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic tgl;
    } dps_sd_s;

    // Main-domain state, one packed struct
    typedef struct packed {
        dps_ilv_s ilv_reg;
        logic [CNT_W-1:0] duty_limit_reg;
        logic signed [`DPS_COEF_W-1:0] proportional_coef_reg;
        logic signed [`DPS_COEF_W-1:0] integral_coef_reg;
        logic signed [`DPS_COEF_W-1:0] derivative_coef_reg;
        logic signed [`DPS_COEF_W-1:0] rolloff_coef_reg;
        logic t1;
        logic t2;
        logic t3;
        dps_state_e st;
        logic [CNT_W-1:0] ph_cnt;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] on_time;
        logic [CNT_W-1:0] lock_cnt;
        logic locked;
        logic pwm;
        logic [14:0] prbs;
        logic signed [`DPS_ERR_W-1:0] err_d;
        logic signed [`DPS_ACC_W-1:0] integ;
        logic signed [`DPS_ACC_W-1:0] dfilt;
        logic signed [`DPS_ERR_W-1:0] resp;
    } dps_st_s;

    dps_sd_s sd_reg, sd_next;
    dps_st_s r_reg, r_next;

    // Helper for assertions: the crossed sync event
    logic sync_ev_w;
    assign sync_ev_w = r_reg.t2 ^ r_reg.t3;

    // Period length in clk cycles for the selected rate
    function automatic logic [CNT_W-1:0] per_len(input dps_fsw_e f);
        per_len = (f == DPS_FSW_1M) ? CNT_W'(`DPS_PER_HI)
                                    : CNT_W'(`DPS_PER_LO);
    endfunction

    // Cycles of delay for a phase step count of one period
    function automatic logic [CNT_W-1:0] ph_delay(input dps_ilv_s c);
        logic [2*CNT_W-1:0] p;
        p = (2*CNT_W)'(per_len(c.fsw)) * (2*CNT_W)'(c.phase);
        ph_delay = CNT_W'(p / (2*CNT_W)'(`DPS_PHASE_STEPS));
    endfunction

    // Saturate a signed accumulator into 0..limit
    function automatic logic [CNT_W-1:0] clamp(
        input logic signed [`DPS_ACC_W-1:0] v,
        input logic [CNT_W-1:0] lim);
        if (v < 0)
            clamp = '0;
        else if (v > $signed({1'b0, lim}))
            clamp = lim;
        else
            clamp = v[CNT_W-1:0];
    endfunction

    // Sync domain: two-flop sample, then a falling-edge toggle
    always_comb begin
        sd_next = sd_reg;
        sd_next.s1 = sync_line;
        sd_next.s2 = sd_reg.s1;
        sd_next.s3 = sd_reg.s2;
        if (sd_reg.s3 && !sd_reg.s2) begin // Falling edge
            sd_next.tgl = ~sd_reg.tgl;
        end
    end

    // The sync clock free-runs from the power manager, so reset holds
    always_ff @(posedge sync_clk) begin
        if (reset) begin
            sd_reg <= '0;
        end else begin
            sd_reg <= sd_next;
        end
    end

    // Main next-state logic
    always_comb begin
        logic sync_ev;
        logic [CNT_W-1:0] per;
        logic signed [`DPS_ACC_W-1:0] e;
        logic signed [`DPS_ACC_W-1:0] de;
        logic signed [`DPS_ACC_W-1:0] u;
        logic signed [`DPS_ACC_W-1:0] duty;
        sync_ev = 1'b0;
        per = '0;
        e = '0;
        de = '0;
        u = '0;
        duty = '0;
        r_next = r_reg;

        // Toggle crossing: only t2/t3 are compared, never t1
        r_next.t1 = sd_reg.tgl;
        r_next.t2 = r_reg.t1;
        r_next.t3 = r_reg.t2;
        sync_ev = r_reg.t2 ^ r_reg.t3;

        // Interleave config held off while the output runs
        if (ilv_wr && !output_on) begin
            r_next.ilv_reg = ilv_wdata; // Rate and phase
        end
        if (duty_wr) begin
            r_next.duty_limit_reg = duty_wdata;
            if (r_reg.on_time > duty_wdata) begin // Lower limit bites now
                r_next.on_time = duty_wdata;
            end
        end
        if (coef_wr) begin
            // Separate coefficient registers
            r_next.proportional_coef_reg = coef_wdata.prop;
            r_next.integral_coef_reg = coef_wdata.integ;
            r_next.derivative_coef_reg = coef_wdata.deriv;
            r_next.rolloff_coef_reg = coef_wdata.rolloff;
        end

        // Lock detect: sync edges must keep arriving
        if (sync_ev) begin
            r_next.lock_cnt = '0;
            r_next.locked = 1'b1;
        end else if (r_reg.lock_cnt == CNT_W'(`DPS_LOCK_TMO)) begin
            r_next.locked = 1'b0;
        end else begin
            r_next.lock_cnt = r_reg.lock_cnt + 1'b1;
        end

        // PRBS-15 advances once per switching period
        per = per_len(r_reg.ilv_reg.fsw); // Own rate selection

        // Period sequencer
        unique case (r_reg.st)
            DPS_ST_IDLE: begin
                r_next.pwm = 1'b0;
                if (sync_ev && output_on) begin
                    r_next.ph_cnt = ph_delay(r_reg.ilv_reg);
                    r_next.st = DPS_ST_WAIT;
                end
            end
            DPS_ST_WAIT: begin
                if (r_reg.ph_cnt == '0) begin
                    r_next.cnt = '0;
                    r_next.pwm = (r_reg.on_time != '0);
                    r_next.st = DPS_ST_RUN;
                end else begin
                    r_next.ph_cnt = r_reg.ph_cnt - 1'b1;
                end
            end
            DPS_ST_RUN: begin
                r_next.cnt = r_reg.cnt + 1'b1;
                r_next.pwm = (r_reg.cnt + 1'b1) < r_reg.on_time;
                if (r_reg.cnt == per - 1'b1 || (sync_ev && output_on)) begin
                    // Period end, or a realigning sync cutting it short
                    e = `DPS_ACC_W'(vout_err);
                    de = e - `DPS_ACC_W'(r_reg.err_d);
                    r_next.err_d = vout_err;
                    r_next.integ = r_reg.integ
                        + r_reg.integral_coef_reg * e;
                    // Derivative with first-order roll-off
                    r_next.dfilt = r_reg.dfilt
                        + ((r_reg.derivative_coef_reg * de
                            - r_reg.dfilt) * r_reg.rolloff_coef_reg
                           >>> `DPS_FRAC);
                    u = (r_reg.proportional_coef_reg * e
                         + r_next.integ + r_next.dfilt) >>> `DPS_FRAC;
                    // Trim around ideal ratio
                    duty = `DPS_ACC_W'(ideal_duty) + u;
                    if (plant_identification) begin
                        duty = r_reg.prbs[0] ? duty + 1 : duty - 1;
                        r_next.resp = vout_err; // Response capture
                    end
                    r_next.prbs = {r_reg.prbs[13:0],
                                   r_reg.prbs[14] ^ r_reg.prbs[13]};
                    // Clamp on-time to limit and period
                    r_next.on_time = clamp(duty,
                        (r_next.duty_limit_reg < per) ?
                        r_next.duty_limit_reg : per);
                    // 1 MHz: restart without waiting; next edge realigns
                    r_next.cnt = '0;
                    r_next.pwm = 1'b0;
                    if (!output_on) begin
                        r_next.st = DPS_ST_IDLE;
                    end else if (r_reg.ilv_reg.fsw == DPS_FSW_500K) begin
                        r_next.st = DPS_ST_IDLE;
                    end else begin
                        r_next.pwm = (r_next.on_time != '0); // As from WAIT
                    end
                end
                if (sync_ev && output_on) begin // Realign each sync
                    r_next.ph_cnt = ph_delay(r_reg.ilv_reg);
                    r_next.pwm = 1'b0;
                    r_next.st = DPS_ST_WAIT;
                end
                if (!output_on) begin
                    r_next.pwm = 1'b0;
                    r_next.st = DPS_ST_IDLE;
                end
            end
            default: r_next.st = DPS_ST_IDLE;
        endcase
    end

    // Main state register with clock enable
    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.duty_limit_reg <= `DPS_DUTY_LIM_RST;
            r_reg.prbs <= `DPS_PRBS_SEED;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // Outputs from flops
    assign pwm_out = r_reg.pwm;
    assign locked = r_reg.locked;
    assign prbs_bit = r_reg.prbs[0];
    assign ilv_reg_q = r_reg.ilv_reg;
    assign duty_limit_reg_q = r_reg.duty_limit_reg;
    assign duty_cmd = r_reg.on_time;
    assign vout_resp = r_reg.resp;

    // Assertions
    sequence s_write_on;
        ilv_wr && output_on && clk_en;
    endsequence

    property p_ilv_hold;
        @(posedge clk) disable iff (reset)
        s_write_on |=> $stable(r_reg.ilv_reg);
    endproperty
    a_ilv_hold_on: assert property (p_ilv_hold)
        else $error("interleave changed while on");

    a_ilv_write_off: assert property (
        @(posedge clk) disable iff (reset)
        ilv_wr && !output_on && clk_en |=> r_reg.ilv_reg == $past(ilv_wdata))
        else $error("interleave write lost");

    a_duty_clamp: assert property (
        @(posedge clk) disable iff (reset)
        r_reg.on_time <= r_reg.duty_limit_reg)
        else $error("on-time above duty limit");

    a_pwm_off_idle: assert property (
        @(posedge clk) disable iff (reset)
        r_reg.st == DPS_ST_IDLE |-> !r_reg.pwm)
        else $error("pwm high while idle");

    a_sync_start: assert property (
        @(posedge clk) disable iff (reset)
        clk_en && r_reg.st == DPS_ST_IDLE && sync_ev_w && output_on |=>
        r_reg.st == DPS_ST_WAIT && r_reg.ph_cnt == ph_delay(r_reg.ilv_reg))
        else $error("phase delay not loaded");

    a_lock_set: assert property (
        @(posedge clk) disable iff (reset)
        clk_en && sync_ev_w |=> r_reg.locked)
        else $error("lock not set on sync edge");

    a_duty_wr: assert property (
        @(posedge clk) disable iff (reset)
        duty_wr && clk_en |=> r_reg.duty_limit_reg == $past(duty_wdata))
        else $error("duty limit not stored");

    a_prbs_step: assert property (
        @(posedge clk) disable iff (reset)
        !clk_en |=> $stable(r_reg.prbs))
        else $error("prbs moved while frozen");

endmodule // dps_pwm_core

// >>> bench/dps_sync_src.sv
/*
 * Power manager model: drives the 500 kHz sync line seen by the converter.
 * Assumes the bench starts and stops it through run; idle level is high.
 */
`timescale 1ns/1ps

module dps_sync_src #(
    parameter real HALF_NS = 1000.0 // Half of the 2000 ns sync period
) (
    // Control from the bench
    input wire logic run,
    // Line to the converter
    output logic sync_line
);
    // Square wave; each falling edge is one sync event
    // A stop lands only at a period boundary, like a real manager.
    initial begin
        sync_line = 1'b1;
        forever begin
            if (run) begin
                #(HALF_NS) sync_line = 1'b0;
                #(HALF_NS) sync_line = 1'b1;
            end else begin
                #(HALF_NS) sync_line = 1'b1; // Line parks high
            end
        end
    end
endmodule // dps_sync_src

// >>> bench/tb_top.sv
/*
 * Bench for dps_pwm_core: writes settings, runs the sync line and the
 * loop inputs, and compares the outputs with worked-out values.
 * Assumes dps_pkg and dps_sync_src are compiled first.
 */
`timescale 1ns/1ps

module tb_top;
    import dps_pkg::*;
    // Clocks, reset, model control
    logic clk = 1'b0;
    logic sync_clk = 1'b0;
    logic reset = 1'b1;
    logic run = 1'b1;
    logic clk_en = 1'b1;
    // Design inputs
    logic ilv_wr = 1'b0;
    dps_ilv_s ilv_wdata = '0;
    logic duty_wr = 1'b0;
    logic [7:0] duty_wdata = 8'h00;
    logic coef_wr = 1'b0;
    dps_coef_s coef_wdata = '0;
    logic output_on = 1'b0;
    logic plant_identification = 1'b0;
    logic [7:0] ideal_duty = 8'h10;
    logic signed [11:0] vout_err = 12'h000;
    // Model and design outputs
    logic sync_line;
    logic pwm_out;
    logic locked;
    logic prbs_bit;
    dps_ilv_s ilv_reg_q;
    logic [7:0] duty_limit_reg_q;
    logic [7:0] duty_cmd;
    logic signed [11:0] vout_resp;
    // Scoreboard and scratch
    int miscompares = 0;
    int check_count = 0;
    int d0;
    int d8;
    int n;
    logic [7:0] dp;
    logic pb;

    // 40 ns core clock, 15 ns sampling clock of unrelated phase
    always #20 clk = ~clk;
    always #7.5 sync_clk = ~sync_clk;

    dps_sync_src i_src (.run, .sync_line);
    dps_pwm_core i_dut (.clk, .reset, .clk_en, .sync_clk, .sync_line,
        .ilv_wr, .ilv_wdata, .duty_wr, .duty_wdata, .coef_wr, .coef_wdata,
        .output_on, .plant_identification, .ideal_duty, .vout_err,
        .pwm_out, .locked, .prbs_bit, .ilv_reg_q, .duty_limit_reg_q,
        .duty_cmd, .vout_resp);

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One comparison; four-state so an unknown matches only an identical unknown
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // Wait k edges, then settle on the falling edge for sampling
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask

    // One-cycle strobe: kind 0 interleave, 1 duty limit, 2 coefficients
    task automatic wr(input int kind, input logic [63:0] v);
        @(posedge clk);
        ilv_wr <= (kind == 0);
        duty_wr <= (kind == 1);
        coef_wr <= (kind == 2);
        ilv_wdata <= v[4:0];
        duty_wdata <= v[7:0];
        coef_wdata <= v;
        @(posedge clk);
        ilv_wr <= 1'b0;
        duty_wr <= 1'b0;
        coef_wr <= 1'b0;
        @(negedge clk);
    endtask

    // Cycles from a sync falling edge to the next PWM rise
    task automatic meas(output int m);
        logic p;
        m = 0;
        do begin
            p = sync_line;
            @(negedge clk);
            m++;
        end while (!(p && !sync_line) && m < 200);
        m = (m >= 200) ? 200 : 0;
        do begin
            p = pwm_out;
            @(negedge clk);
            m++;
        end while (!(!p && pwm_out) && m < 200);
        if (m >= 200) begin
            miscompares++;
            complete_run();
        end
    endtask

    // PWM rising edges over 200 cycles (four sync periods)
    task automatic rises(output int r);
        logic p;
        p = pwm_out;
        r = 0;
        repeat (200) begin
            @(negedge clk);
            if (!p && pwm_out) r++;
            p = pwm_out;
        end
    endtask

    // Main sequence
    initial begin
        cyc(5);
        chk("limit_rst", duty_limit_reg_q, 8'hff);
        chk("ilv_rst", ilv_reg_q, 5'h00);
        @(posedge clk);
        reset <= 1'b0;
        n = 0;
        while (locked !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk("lock", locked, 1'b1);
        if (n >= 300) complete_run();
        wr(1, 64'h0a);
        chk("limit", duty_limit_reg_q, 8'h0a);
        wr(0, {DPS_FSW_500K, 4'h0});
        chk("ilv", ilv_reg_q, 5'h00);
        @(posedge clk);
        ideal_duty <= 8'h20;
        output_on <= 1'b1;
        cyc(150);
        chk("clamp", duty_cmd, 8'h0a);
        meas(d0);
        n = 0;
        while (pwm_out === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk("on_time", n, 10);
        // Refused while running: value must stay
        wr(0, {DPS_FSW_1M, 4'h8});
        chk("refused", ilv_reg_q, 5'h00);
        wr(1, 64'hff);
        @(posedge clk);
        ideal_duty <= 8'h10;
        cyc(150);
        meas(d0);
        chk("sync_lat", d0 <= 10, 1'b1);
        rises(n);
        chk("rate_500k", n >= 3 && n <= 5, 1'b1);
        @(posedge clk);
        output_on <= 1'b0;
        wr(0, {DPS_FSW_500K, 4'h8});
        chk("ilv_off", ilv_reg_q, {DPS_FSW_500K, 4'h8});
        @(posedge clk);
        output_on <= 1'b1;
        cyc(150);
        // Half a period (8 of 16 steps) is 25 cycles; allow sync jitter
        meas(d8);
        chk("phase", d8 - d0 >= 23 && d8 - d0 <= 27, 1'b1);
        @(posedge clk);
        output_on <= 1'b0;
        wr(0, {DPS_FSW_1M, 4'h0});
        @(posedge clk);
        output_on <= 1'b1;
        cyc(150);
        rises(n);
        chk("rate_1m", n >= 7 && n <= 9, 1'b1);
        // Proportional gain 1.0 only, so trim equals the error
        wr(2, {16'h0100, 48'h0});
        @(posedge clk);
        vout_err <= 12'sd4;
        cyc(150);
        chk("trim", duty_cmd, 8'h14);
        @(posedge clk);
        vout_err <= -12'sd4;
        cyc(150);
        chk("pid_sign", duty_cmd, 8'h0c);
        // Quiet loop loaded before identification starts
        wr(2, 64'h0);
        @(posedge clk);
        vout_err <= 12'sd5;
        plant_identification <= 1'b1;
        cyc(150);
        chk("resp", vout_resp, 12'sd5);
        chk("inject", duty_cmd == 8'h0f || duty_cmd == 8'h11, 1'b1);
        n = 0;
        pb = prbs_bit;
        repeat (800) begin
            @(negedge clk);
            if (prbs_bit !== pb) n++;
            pb = prbs_bit;
        end
        chk("prbs_moves", n > 0, 1'b1);
        // Clock enable low: sequence and command must freeze
        @(posedge clk);
        clk_en <= 1'b0;
        cyc(1);
        pb = prbs_bit;
        dp = duty_cmd;
        cyc(100);
        chk("frz_prbs", prbs_bit, pb);
        chk("frz_duty", duty_cmd, dp);
        @(posedge clk);
        clk_en <= 1'b1;
        // Stop the manager: lock holds, then drops after 100 cycles
        run = 1'b0;
        cyc(60);
        chk("hold_lock", locked, 1'b1);
        cyc(110);
        chk("lost_lock", locked, 1'b0);
        complete_run();
    end

    // Cut a hang short
    initial begin
        #2000000;
        miscompares++;
        complete_run();
    end
endmodule // tb_top
